// file: rtl/srt_top.sv
// region configuration words and per-step runtime timer for the integrity checker
// How it works
// - variant code 0 is SHA-1, 1 is SHA-256, 4 is SHA-224; others reserved.
// - every variant has a short and a long step, picked by one region bit.
// - runtime select 0 gives the shortest step for the chosen variant.
// - runtime select 1 gives the longest step for the chosen variant.
// - SHA-1 steps take 85 or 209 cycles; SHA-224/256 take 72 or 194.
`timescale 1ns/1ps
module srt_top #(
   parameter int unsigned NUM_REGIONS = srt_pkg::NUM_REGIONS
) (
   input  wire logic                                clk,
   input  wire logic                                sys_rst,
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [srt_pkg::ADDR_W-1:0]          paddr,
   input  wire logic [srt_pkg::DATA_W-1:0]          pwdata,
   output logic      [srt_pkg::DATA_W-1:0]          prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   input  wire logic                                step_start,
   input  wire logic [$clog2(NUM_REGIONS)-1:0]      step_region,
   output logic                                     step_busy,
   output logic                                     step_done,
   output logic                                     step_err,
   output logic      [2:0]                          step_variant
);
   localparam int unsigned RW = $clog2(NUM_REGIONS);

   logic [31:0]              region_q [NUM_REGIONS];
   logic [31:0]              prdata_q;
   srt_pkg::srt_state_t      state_q;
   logic [7:0]               count_q;
   logic [RW-1:0]            cur_region_q;
   logic [2:0]               cur_variant_q;
   logic                     done_q;
   logic                     err_q;
   logic                     err_sticky_q;

   // address decode
   wire logic [11:0]         rel_addr   = paddr - srt_pkg::OFS_REGION_BASE;
   wire logic [RW-1:0]       reg_index  = rel_addr[4 +: RW];
   wire logic                hit_status = (paddr == srt_pkg::OFS_STATUS);
   wire logic                hit_region = (paddr >= srt_pkg::OFS_REGION_BASE) &&
                                          (rel_addr[3:0] == 4'h0) &&
                                          (rel_addr[11:4] < 8'(NUM_REGIONS));
   wire logic                mapped     = hit_status || hit_region;
   wire logic                setup      = psel && !penable;
   wire logic                wr_access  = psel && penable && pwrite && hit_region;

   // one write enable per region word
   logic [NUM_REGIONS-1:0]   region_we;

   for (genvar g = 0; g < int'(NUM_REGIONS); g++) begin : g_region_we
      assign region_we[g] = wr_access && (reg_index == RW'(g));
   end

   // selected region's fields
   wire logic [31:0]         sel_word   = region_q[step_region];
   wire logic [2:0]          sel_var    = sel_word[srt_pkg::VARIANT_LSB +: srt_pkg::VARIANT_W];
   wire logic                sel_long   = sel_word[srt_pkg::RUNLEN_BIT];

   // variant decode
   wire logic                var_sha1   = (sel_var == srt_pkg::VARIANT_SHA1);
   wire logic                var_sha256 = (sel_var == srt_pkg::VARIANT_SHA256);
   wire logic                var_sha224 = (sel_var == srt_pkg::VARIANT_SHA224);
   wire logic                var_sha2   = var_sha256 || var_sha224;
   wire logic                var_ok     = var_sha1 || var_sha2;

   // short/long per variant 0 picks shortest 1 longest
   wire logic [7:0]          sha1_len   = sel_long ? srt_pkg::SHA1_LONG
                                                   : srt_pkg::SHA1_SHORT;
   wire logic [7:0]          sha2_len   = sel_long ? srt_pkg::SHA2_LONG
                                                   : srt_pkg::SHA2_SHORT;

   // reserved codes never launch, so their length is a don't-care
   wire logic [7:0]          step_len   = var_sha1 ? sha1_len : sha2_len;

   // step handshake
   wire logic                idle       = (state_q == srt_pkg::SRT_IDLE);
   wire logic                launch     = idle && step_start && var_ok;
   wire logic                reject     = idle && step_start && !var_ok;

   // status fields
   wire logic                st_busy    = !idle;
   wire logic                st_err     = err_sticky_q;
   wire logic [1:0]          st_region  = 2'(cur_region_q);
   wire logic [2:0]          st_variant = cur_variant_q;
   wire logic [7:0]          st_count   = count_q;

   wire logic [31:0]         status_word = {8'h00,
                                            st_count,
                                            5'h00,
                                            st_variant,
                                            2'h0,
                                            st_region,
                                            2'h0,
                                            st_err,
                                            st_busy};

   // read mux; unmapped reads return zero
   wire logic [31:0]         rd_mux     = hit_status ? status_word :
                                          hit_region ? region_q[reg_index] : 32'h00000000;

   // no wait states: every access phase completes in one cycle
   assign pready       = 1'b1;
   assign pslverr      = psel && penable && !mapped;
   assign prdata       = prdata_q;

   // step outputs
   assign step_busy    = !idle;
   assign step_done    = done_q;
   assign step_err     = err_q;
   assign step_variant = cur_variant_q;

   // region words; reserved bits never stored
   always_ff @(posedge clk) begin
      for (int i = 0; i < int'(NUM_REGIONS); i++) begin
         if (sys_rst) begin
            region_q[i] <= srt_pkg::REGION_RESET;
         end else if (region_we[i]) begin
            region_q[i] <= pwdata & srt_pkg::REGION_WMASK;
         end
      end
   end

   // a write to the running region does not disturb the step in flight:
   // variant and count are latched at launch

   // read data captured in setup so it is stable for the whole access
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata_q <= 32'h00000000;
      end else if (setup && !pwrite) begin
         prdata_q <= rd_mux;
      end
   end


   // step timer; word is sampled at launch, later writes affect only next step
   // count runs down to zero so the busy window is exactly the step length
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q       <= srt_pkg::SRT_IDLE;
         count_q       <= 8'h00;
         cur_region_q  <= '0;
         cur_variant_q <= 3'h0;
         done_q        <= 1'b0;
         err_q         <= 1'b0;
      end else begin
         done_q <= 1'b0;
         err_q  <= reject;
         case (state_q)
            srt_pkg::SRT_IDLE: begin
               if (launch) begin
                  state_q       <= srt_pkg::SRT_RUN;
                  count_q       <= step_len - 8'h01;
                  cur_region_q  <= step_region;
                  cur_variant_q <= sel_var;
               end
            end
            srt_pkg::SRT_RUN: begin
               if (count_q == 8'h00) begin
                  state_q <= srt_pkg::SRT_IDLE;
                  done_q  <= 1'b1;
               end else begin
                  count_q <= count_q - 8'h01;
               end
            end
            default: begin
               state_q <= srt_pkg::SRT_IDLE;
            end
         endcase
      end
   end


   // sticky error; a new reject wins over a same-cycle clear
   // so software never loses a refusal that lands with its clear
   wire logic err_clr = psel && penable && pwrite && hit_status && pwdata[srt_pkg::ST_ERR_BIT];
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         err_sticky_q <= 1'b0;
      end else if (reject) begin
         err_sticky_q <= 1'b1;
      end else if (err_clr) begin
         err_sticky_q <= 1'b0;
      end
   end
endmodule : srt_top

// file: rtl/srt_pkg.sv
// constants for the region configuration and step timing block
package srt_pkg;
   localparam int unsigned    ADDR_W          = 12;
   localparam int unsigned    DATA_W          = 32;
   localparam int unsigned    NUM_REGIONS     = 4;
   localparam int unsigned    CNT_W           = 8;
   // register map
   localparam logic [11:0]    OFS_STATUS      = 12'h000;
   localparam logic [11:0]    OFS_REGION_BASE = 12'h004;
   localparam logic [11:0]    OFS_REGION_STEP = 12'h010;
   localparam logic [31:0]    REGION_RESET    = 32'h00000000;
   // fields of the region configuration word
   localparam int unsigned    VARIANT_LSB     = 12;
   localparam int unsigned    VARIANT_W       = 3;
   localparam int unsigned    RUNLEN_BIT      = 10;
   localparam logic [31:0]    REGION_WMASK    = 32'h000077F7;
   // variant codes
   localparam logic [2:0]     VARIANT_SHA1    = 3'h0;
   localparam logic [2:0]     VARIANT_SHA256  = 3'h1;
   localparam logic [2:0]     VARIANT_SHA224  = 3'h4;
   // cycles per processing step
   localparam logic [7:0]     SHA1_SHORT      = 8'd85;
   localparam logic [7:0]     SHA1_LONG       = 8'd209;
   localparam logic [7:0]     SHA2_SHORT      = 8'd72;
   localparam logic [7:0]     SHA2_LONG       = 8'd194;
   // status fields
   localparam int unsigned    ST_BUSY_BIT     = 0;
   localparam int unsigned    ST_ERR_BIT      = 1;
   localparam int unsigned    ST_REGION_LSB   = 4;
   localparam int unsigned    ST_VARIANT_LSB  = 8;
   localparam int unsigned    ST_COUNT_LSB    = 16;

   typedef enum logic [1:0] {
      SRT_IDLE = 2'b01,
      SRT_RUN  = 2'b10
   } srt_state_t;
endpackage : srt_pkg

// file: dv/srt_asserts.sv
// port checker for the step timer
`timescale 1ns/1ps
module srt_asserts (
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       step_start,
   input wire logic       step_busy,
   input wire logic       step_done,
   input wire logic       step_err,
   input wire logic [2:0] step_variant
);
   logic [7:0] busy_cnt_q;
   // counts busy cycles, holds the full count in the done cycle
   always_ff @(posedge clk) busy_cnt_q <= (sys_rst || !step_busy) ? 8'h00 : busy_cnt_q + 8'h01;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sha1_len_a: assert property (step_done && step_variant == srt_pkg::VARIANT_SHA1 |->
      busy_cnt_q == 8'h55 || busy_cnt_q == 8'hD1) else $error("sha1 step length");
   sha2_len_a: assert property (step_done && step_variant != srt_pkg::VARIANT_SHA1 |->
      busy_cnt_q == 8'h48 || busy_cnt_q == 8'hC2) else $error("sha2 step length");
   done_end_a: assert property (step_done |-> !step_busy && $past(step_busy))
      else $error("done without a step");
   launch_a: assert property (step_start && !step_busy |=> step_busy != step_err)
      else $error("start not answered");
   known_var_a: assert property (step_busy |-> step_variant inside {3'h0, 3'h1, 3'h4})
      else $error("step runs a reserved variant");
   var_hold_a: assert property (step_busy && $past(step_busy) |-> $stable(step_variant))
      else $error("variant changed mid step");
   err_idle_a: assert property (step_err |-> !step_busy && !step_done)
      else $error("error while running");
endmodule : srt_asserts
bind srt_top srt_asserts u_chk (.clk, .sys_rst, .step_start, .step_busy, .step_done,
   .step_err, .step_variant);

// file: dv/test_srt_top.sv
// self-checking bench for the region words and step timer
`timescale 1ns/1ps
module test_srt_top;
   logic        clk, sys_rst, psel, penable, pwrite, step_start, se;
   logic        pready, pslverr, step_busy, step_done, step_err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0]  step_region;
   logic [2:0]  step_variant;
   int          fails, n_checks, n;
   logic [31:0] cfg [4] = '{32'h00000000, 32'h00000400, 32'h00004000, 32'h00001400};
   logic [7:0]  len [4] = '{srt_pkg::SHA1_SHORT, srt_pkg::SHA1_LONG, srt_pkg::SHA2_SHORT,
                            srt_pkg::SHA2_LONG};
   srt_top #(.NUM_REGIONS(4)) uut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .step_start, .step_region, .step_busy, .step_done,
      .step_err, .step_variant);
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // start taken at one edge, then count busy cycles up to the done cycle
   task automatic run_step(input logic [1:0] r, input logic [7:0] exp_n, input logic [1:0] f);
      @(posedge clk);
      step_start <= 1'b1;
      step_region <= r;
      @(posedge clk);
      step_start <= 1'b0;
      #1;
      n = 0;
      while (step_busy === 1'b1 && n < 300) begin
         n++;
         @(posedge clk);
         #1;
      end
      check("step cycles", 32'(n), {24'h000000, exp_n});
      check("done err", {30'h00000000, step_done, step_err}, {30'h00000000, f});
   endtask : run_step
   task automatic end_sim();
      if (fails == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_sim
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #50000;
      fails++;
      end_sim();
   end
   initial begin
      {sys_rst, psel, penable, pwrite, step_start} = 5'h10;
      {paddr, pwdata, step_region} = '0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      apb(1'b0, 12'h004, 32'h00000000);
      check("reset word", rd, srt_pkg::REGION_RESET);
      for (int r = 0; r < 4; r++) apb(1'b1, 12'h004 + 12'(r) * 12'h010, cfg[r]);
      // each region keeps its own variant and length, run in turn
      for (int r = 0; r < 4; r++) begin
         apb(1'b0, 12'h004 + 12'(r) * 12'h010, 32'h00000000);
         check("region word", rd, cfg[r]);
         run_step(2'(r), len[r], 2'b10);
         check("variant", {29'h00000000, step_variant}, {29'h00000000, cfg[r][14:12]});
      end
      apb(1'b1, 12'h014, 32'hFFFFFFFF);
      apb(1'b0, 12'h014, 32'h00000000);
      check("masked word", rd, srt_pkg::REGION_WMASK);
      for (int v = 2; v < 8; v++) if (v != 4) begin
         apb(1'b1, 12'h014, 32'(v) << 12);
         run_step(2'h1, 8'h00, 2'b01);
      end
      // last launch was region 3, variant 1; rejects set the sticky error
      apb(1'b0, 12'h000, 32'h00000000);
      check("status err", rd, 32'h00000132);
      apb(1'b1, 12'h000, 32'h00000002);
      apb(1'b0, 12'h000, 32'h00000000);
      check("status clr", rd, 32'h00000130);
      apb(1'b0, 12'hFF0, 32'h00000000);
      check("unmapped err", {31'h00000000, se}, 32'h00000001);
      check("unmapped data", rd, 32'h00000000);
      end_sim();
   end
endmodule : test_srt_top
